// file: rdg_ctrl.sv
// reading buffer, terminator, pacing and converter sequencing control
`timescale 1ns/10ps
`default_nettype none
module rdg_ctrl
    import rdg_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        line_50hz,
    input  wire logic        byte_ack,
    output logic      [7:0]  tx_byte,
    output logic             tx_valid,
    output logic             tx_last,
    output logic             srq,
    output logic             panel_lockout,
    output logic             display_blank,
    output logic             adc_integrate,
    output logic             adc_autozero,
    output logic             adc_autocal,
    output logic             rdg_ready
);
    localparam int C_GAP  = T_FAST_GAP_US * CLK_MHZ;
    localparam int C_SLOW = T_SLOW_HOST_US * CLK_MHZ;
    localparam int C_EXT  = T_HS_EXT_US * CLK_MHZ;

    typedef struct packed {
        logic [2:0]  depth_p, depth;
        logic [1:0]  term_p, term;
        logic [7:0]  tchar_p, tchar;
        logic        filt_p, filt;
        logic [1:0]  zchk_p, zchk;
        logic        zcu_p, zcu;
        logic        bcap_p, bcap;
        logic        bsub_p, bsub;
        logic        sub_act;
        logic [2:0]  trig_p, trig;
        logic        resp_p, resp;
        logic [3:0]  rate_p, rate;
        logic        bin_p, bin;
        logic        chan_p, chan;
        logic [1:0]  func_p, func;
        logic [3:0]  rng_p, rng;
        logic        op_pend;
        logic [5:0]  wr_ptr, rd_ptr, count, sent;
        logic        full;
        logic [4:0]  bidx, blen;
        logic [31:0] cur;
        logic        busy;
        logic [7:0]  tx_byte;
        logic        tx_valid, tx_last;
        logic [31:0] gap, wait_c;
        logic        srq;
        logic        err;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic [2:0]  sseq;
        logic [31:0] stime, lat;
        logic [1:0]  extra;
        logic        trig_pend;
        logic        int_o, az_o, ac_o, rdy;
        logic        chg_fr, chg_ch, chg_up, chg_dn;
    } st_type;

    st_type q, d;
    logic [31:0] fifo_q [DEPTH];
    logic [31:0] zc_q [6];
    logic [31:0] bl_q [6];
    logic        push, cap_zc, cap_bl;
    logic [31:0] push_val, raw_val;
    logic [2:0]  sel_idx;

    function automatic logic [5:0] depth_cnt(input logic [2:0] dg);
        depth_cnt = (dg == 3'h0) ? 6'h01 : 6'(GROUP * dg);
    endfunction
    function automatic logic [31:0] int_cyc(input logic [3:0] r,
                                            input logic hz50);
        if (r == 4'h0) int_cyc = 32'(T_INT_FAST_US * CLK_MHZ);
        else if (r <= 4'h3)
            int_cyc = hz50 ? 32'(T_INT_50_US * CLK_MHZ)
                           : 32'(T_INT_60_US * CLK_MHZ);
        else int_cyc = 32'(T_INT_SLOW_US * CLK_MHZ);
    endfunction
    function automatic logic reserved(input logic [7:0] c);
        reserved = (c == 8'h45) || (c == 8'h52) || (c == 8'h4D) ||
                   (c == 8'h54) || (c == 8'h44) || (c == 8'h51) ||
                   (c == 8'h59) || (c == 8'h53) || (c == 8'h50) ||
                   (c == 8'h5A) || (c == 8'h4E) || (c == 8'h55) ||
                   (c == 8'h58);
    endfunction

    logic acc;
    logic [7:0] op, arg;
    assign acc = psel && penable && !q.pready;
    assign op  = pwdata[15:8];
    assign arg = pwdata[7:0];
    assign sel_idx = (q.chan ? 3'h3 : 3'h0) + {1'b0, q.func};

    always_comb begin
        d = q;
        push = 1'b0;
        cap_zc = 1'b0;
        cap_bl = 1'b0;
        raw_val = pwdata;
        push_val = raw_val - (q.sub_act ? bl_q[sel_idx] : 32'h0);
        d.pready = acc;
        d.pslverr = 1'b0;
        d.srq = 1'b0;
        d.rdy = 1'b0;
        d.prdata = 32'h0;
        if (acc && pwrite && paddr == OFF_CMD) begin
            case (op)
                OP_DEPTH:  if (arg[2:0] <= MAX_DIGIT && arg[7:3] == 5'h0)
                               d.depth_p = arg[2:0];
                           else d.err = 1'b1;
                OP_TERM: begin
                    if (arg == CH_DEL) d.term_p = TERM_NONE;
                    else if (arg == CH_CR) d.term_p = TERM_LFCR;
                    else if (arg == CH_LF) d.term_p = TERM_CRLF;
                    else if (!reserved(arg)) begin
                        d.term_p = TERM_ONE;
                        d.tchar_p = arg;
                    end else d.err = 1'b1;
                end
                OP_FILTER: d.filt_p = arg[0];
                OP_ZCHK:   d.zchk_p[q.chan_p] = arg[0];
                OP_ZCOR:   d.zcu_p = arg[0];
                OP_BCAP:   d.bcap_p = arg[0];
                OP_BSUB:   d.bsub_p = arg[0];
                OP_TRIG:   if (arg <= 8'(TRIG_SHOT_COMMIT)) d.trig_p = arg[2:0];
                           else d.err = 1'b1;
                OP_RESP:   d.resp_p = arg[0];
                OP_RATE:   d.rate_p = arg[3:0];
                OP_FMT:    d.bin_p = arg[0];
                OP_CHAN:   d.chan_p = arg[0];
                OP_FUNC:   if (arg < 8'h03) d.func_p = arg[1:0];
                           else d.err = 1'b1;
                OP_RANGE:  d.rng_p = arg[3:0];
                OP_COMMIT: begin
                    d.depth = q.depth_p;
                    d.term = q.term_p;
                    d.tchar = q.tchar_p;
                    d.filt = q.filt_p;
                    d.zchk = q.zchk_p;
                    d.zcu = q.zcu_p;
                    d.bcap = q.bcap_p;
                    d.bsub = q.bsub_p;
                    d.trig = q.trig_p;
                    d.resp = q.resp_p;
                    d.rate = q.rate_p;
                    d.bin = q.bin_p;
                    d.chan = q.chan_p;
                    d.func = q.func_p;
                    d.rng = q.rng_p;
                    d.op_pend = q.zcu_p | q.bcap_p | (q.bsub_p != q.sub_act)
                              | (q.zchk_p != q.zchk);
                    d.chg_fr = (q.func_p != q.func) || (q.rng_p != q.rng);
                    d.chg_ch = q.chan_p != q.chan;
                    d.chg_up = (q.rate_p != q.rate) && (q.rate_p > q.rate);
                    d.chg_dn = (q.rate_p != q.rate) && (q.rate_p < q.rate);
                    if (d.chg_ch || q.rng_p != q.rng)
                        d.extra = 2'(EXTRA_INTS);
                    d.wr_ptr = 6'h0;
                    d.rd_ptr = 6'h0;
                    d.count = 6'h0;
                    d.sent = 6'h0;
                    d.full = 1'b0;
                    if (q.trig_p == TRIG_SHOT_COMMIT ||
                        q.trig_p == TRIG_CONT_COMMIT)
                        d.trig_pend = 1'b1;
                end
                OP_TALK:   if (q.trig == TRIG_SHOT_TALK ||
                               q.trig == TRIG_CONT_TALK)
                               d.trig_pend = 1'b1;
                OP_CLEAR:  d = '0;
                default:   d.err = 1'b1;
            endcase
            if (op == OP_CLEAR) begin
                d.zchk = 2'b11;
                d.zchk_p = 2'b11;
                d.term = TERM_CRLF;
                d.term_p = TERM_CRLF;
                d.rate = 4'h3;
                d.rate_p = 4'h3;
                d.rng = 4'h4;
                d.rng_p = 4'h4;
                d.pready = 1'b1;
            end
        end else if (acc && pwrite && paddr == OFF_RDG_IN) begin
            d.rdy = 1'b1;
            if (q.op_pend) begin
                cap_zc = q.zcu && q.zchk[q.chan];
                cap_bl = q.bcap;
                d.zcu = 1'b0;
                d.zcu_p = 1'b0;
                d.bcap = 1'b0;
                d.bcap_p = 1'b0;
                d.sub_act = q.bsub;
                d.op_pend = 1'b0;
                if (q.zcu && !q.zchk[q.chan]) d.err = 1'b1;
            end
            if (q.count < depth_cnt(q.depth) && !q.full) begin
                push = 1'b1;
                d.wr_ptr = (q.wr_ptr == 6'(DEPTH - 1)) ? 6'h0 : q.wr_ptr + 6'h1;
                d.count = q.count + 6'h1;
                if (d.count == depth_cnt(q.depth)) begin
                    d.full = 1'b1;
                    d.srq = q.resp;
                end
            end
        end else if (acc && !pwrite) begin
            if (paddr == OFF_STAT)
                d.prdata = {13'h0, q.sub_act, q.sseq, q.err, q.full, q.busy,
                            q.count, q.sent};
            else if (paddr == OFF_CFG)
                d.prdata = {q.tchar, q.rng, q.func, q.chan, q.bin, q.rate,
                            q.resp, q.trig, q.zchk, q.filt, q.term, q.depth};
            else if (paddr == OFF_RDG_OUT) d.prdata = fifo_q[q.rd_ptr];
            else if (paddr == OFF_ZCOR) d.prdata = zc_q[sel_idx];
            else if (paddr == OFF_EVT) begin
                d.prdata = {31'h0, q.err};
                d.err = 1'b0;
            end else d.pslverr = 1'b1;
        end else if (acc) begin
            if (paddr != OFF_CMD && paddr != OFF_RDG_IN) d.pslverr = 1'b1;
        end
        if (d.err && !q.err) d.srq = q.resp;
        // transmit one reading string per ready slot
        if (q.gap != 32'h0) d.gap = q.gap - 32'h1;
        if (!q.busy && q.full && q.gap == 32'h0) begin
            d.cur = fifo_q[q.rd_ptr];
            d.busy = 1'b1;
            d.bidx = 5'h0;
            if (q.bin) d.blen = BIN_LEN;
            else case (q.term)
                TERM_NONE: d.blen = TXT_BODY;
                TERM_ONE:  d.blen = TXT_BODY + 5'h1;
                default:   d.blen = TXT_BODY + 5'h2;
            endcase
            d.tx_valid = 1'b1;
            d.tx_byte = fifo_q[q.rd_ptr][31:24];
            d.tx_last = 1'b0;
            d.wait_c = 32'h0;
        end else if (q.busy && q.tx_valid) begin
            d.wait_c = q.wait_c + 32'h1;
            if (byte_ack) begin
                if (q.wait_c > 32'(C_SLOW)) begin
                    d.wait_c = 32'(C_EXT);
                    d.tx_valid = 1'b0;
                end else d.wait_c = 32'h0;
                d.tx_valid = (q.wait_c > 32'(C_SLOW)) ? 1'b0 : !q.tx_last;
                d.bidx = q.bidx + 5'h1;
                if (q.tx_last) begin
                    d.busy = 1'b0;
                    d.tx_valid = 1'b0;
                    d.tx_last = 1'b0;
                    if (q.rate == 4'h0) d.gap = 32'(C_GAP);
                    d.rd_ptr = (q.rd_ptr == 6'(DEPTH - 1)) ? 6'h0
                                                           : q.rd_ptr + 6'h1;
                    d.sent = q.sent + 6'h1;
                    if (d.sent == depth_cnt(q.depth)) begin
                        d.full = 1'b0;
                        d.count = 6'h0;
                        d.sent = 6'h0;
                        d.rd_ptr = 6'h0;
                        d.wr_ptr = 6'h0;
                    end
                end
            end
        end else if (q.busy && q.wait_c != 32'h0) begin
            d.wait_c = q.wait_c - 32'h1;
            if (q.wait_c == 32'h1) d.tx_valid = 1'b1;
        end
        if (q.busy && d.tx_valid) begin
            if (q.bin || d.bidx < TXT_BODY)
                d.tx_byte = q.cur[8'(5'h3 - d.bidx[1:0]) * 8 +: 8];
            else if (q.term == TERM_ONE) d.tx_byte = q.tchar;
            else if (d.bidx == TXT_BODY)
                d.tx_byte = (q.term == TERM_LFCR) ? CH_LF : CH_CR;
            else d.tx_byte = (q.term == TERM_LFCR) ? CH_CR : CH_LF;
            d.tx_last = d.bidx == q.blen - 5'h1;
        end
        // converter sequencer
        d.int_o = 1'b0;
        d.az_o = 1'b0;
        d.ac_o = 1'b0;
        if (q.stime != 32'h0) d.stime = q.stime - 32'h1;
        case (seq_type'(q.sseq))
            SQ_IDLE, SQ_AZ, SQ_AC: begin
                if (q.trig_pend) begin
                    d.trig_pend = 1'b0;
                    d.lat = q.chg_ch ? 32'(T_LAT_CH_US * CLK_MHZ) :
                            q.chg_dn ? 32'(T_LAT_DN_US * CLK_MHZ) :
                            q.chg_up ? 32'(T_LAT_UP_US * CLK_MHZ) :
                            q.chg_fr ? 32'(T_LAT_FR_US * CLK_MHZ) : 32'h0;
                    d.chg_ch = 1'b0;
                    d.chg_dn = 1'b0;
                    d.chg_up = 1'b0;
                    d.chg_fr = 1'b0;
                    d.stime = d.lat;
                    d.sseq = 3'(SQ_LAT);
                end else if (seq_type'(q.sseq) != SQ_IDLE) begin
                    d.az_o = seq_type'(q.sseq) == SQ_AZ;
                    d.ac_o = seq_type'(q.sseq) == SQ_AC;
                    if (q.stime == 32'h0) begin
                        d.sseq = (seq_type'(q.sseq) == SQ_AZ) ? 3'(SQ_AC)
                                                              : 3'(SQ_AZ);
                        d.stime = int_cyc(q.rate, line_50hz);
                    end
                end
            end
            SQ_LAT: if (q.stime == 32'h0) begin
                d.sseq = 3'(SQ_REF);
                d.stime = 32'(q.extra) * int_cyc(q.rate, line_50hz);
            end
            SQ_REF: begin
                d.az_o = 1'b1;
                d.ac_o = 1'b1;
                if (q.stime == 32'h0) begin
                    d.extra = 2'h0;
                    d.sseq = 3'(SQ_SIG);
                    d.stime = int_cyc(q.rate, line_50hz);
                end
            end
            SQ_SIG: begin
                d.int_o = 1'b1;
                if (q.stime == 32'h0) begin
                    d.sseq = 3'(SQ_AZ);
                    d.stime = int_cyc(q.rate, line_50hz);
                    if (q.trig == TRIG_CONT_TALK || q.trig == TRIG_CONT_GET ||
                        q.trig == TRIG_CONT_COMMIT)
                        d.trig_pend = !q.full;
                end
            end
            default: d.sseq = 3'(SQ_IDLE);
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q <= '0;
            q.zchk <= 2'b11;
            q.zchk_p <= 2'b11;
            q.term <= TERM_CRLF;
            q.term_p <= TERM_CRLF;
            q.rate <= 4'h3;
            q.rate_p <= 4'h3;
            q.rng <= 4'h4;
            q.rng_p <= 4'h4;
        end else if (ce) begin
            q <= d;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int i = 0; i < 6; i++) begin
                zc_q[i] <= 32'h0;
                bl_q[i] <= 32'h0;
            end
        end else if (ce) begin
            if (push) fifo_q[q.wr_ptr] <= push_val;
            if (cap_zc) zc_q[sel_idx] <= raw_val;
            if (cap_bl) bl_q[sel_idx] <= raw_val;
        end
    end

    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign tx_byte = q.tx_byte;
    assign tx_valid = q.tx_valid;
    assign tx_last = q.tx_last;
    assign srq = q.srq;
    assign panel_lockout = q.bin;
    assign display_blank = q.bin;
    assign adc_integrate = q.int_o;
    assign adc_autozero = q.az_o;
    assign adc_autocal = q.ac_o;
    assign rdg_ready = q.rdy;
endmodule
`default_nettype wire

// file: rdg_pkg.sv
// package: constants and types for reading buffer and correction control
package rdg_pkg;
    localparam int CLK_MHZ = 100;
    // register byte offsets
    localparam logic [7:0] OFF_CMD    = 8'h00;
    localparam logic [7:0] OFF_CFG    = 8'h04;
    localparam logic [7:0] OFF_STAT   = 8'h08;
    localparam logic [7:0] OFF_RDG_IN = 8'h0C;
    localparam logic [7:0] OFF_RDG_OUT= 8'h10;
    localparam logic [7:0] OFF_EVT    = 8'h14;
    localparam logic [7:0] OFF_ZCOR   = 8'h18;
    // command opcodes in OFF_CMD bits [15:8], argument bits [7:0]
    localparam logic [7:0] OP_DEPTH   = 8'h01;
    localparam logic [7:0] OP_TERM    = 8'h02;
    localparam logic [7:0] OP_FILTER  = 8'h03;
    localparam logic [7:0] OP_ZCHK    = 8'h04;
    localparam logic [7:0] OP_ZCOR    = 8'h05;
    localparam logic [7:0] OP_BCAP    = 8'h06;
    localparam logic [7:0] OP_BSUB    = 8'h07;
    localparam logic [7:0] OP_TRIG    = 8'h08;
    localparam logic [7:0] OP_RESP    = 8'h09;
    localparam logic [7:0] OP_RATE    = 8'h0A;
    localparam logic [7:0] OP_FMT     = 8'h0B;
    localparam logic [7:0] OP_COMMIT  = 8'h0C;
    localparam logic [7:0] OP_CHAN    = 8'h0D;
    localparam logic [7:0] OP_FUNC    = 8'h0E;
    localparam logic [7:0] OP_RANGE   = 8'h0F;
    localparam logic [7:0] OP_CLEAR   = 8'h10;
    localparam logic [7:0] OP_TALK    = 8'h11;
    // terminator argument codes
    localparam logic [7:0] CH_DEL = 8'h7F;
    localparam logic [7:0] CH_CR  = 8'h0D;
    localparam logic [7:0] CH_LF  = 8'h0A;
    localparam logic [2:0] MAX_DIGIT = 3'h5;
    localparam logic [5:0] GROUP = 6'h0A;
    localparam int DEPTH = 50;
    localparam logic [4:0] TXT_BODY = 5'h10;
    localparam logic [4:0] BIN_LEN  = 5'h04;
    // times in microseconds
    localparam int T_FAST_GAP_US = 6000;
    localparam int T_SLOW_HOST_US = 5200;
    localparam int T_HS_EXT_US = 3000;
    localparam int T_INT_FAST_US = 4100;
    localparam int T_INT_60_US = 16660;
    localparam int T_INT_50_US = 20000;
    localparam int T_INT_SLOW_US = 100000;
    localparam int T_LAT_FR_US = 3000;
    localparam int T_LAT_CH_US = 42000;
    localparam int T_LAT_UP_US = 48000;
    localparam int T_LAT_DN_US = 114000;
    localparam int EXTRA_INTS = 2;
    typedef enum logic [2:0] {TRIG_CONT_TALK, TRIG_SHOT_TALK, TRIG_CONT_GET,
        TRIG_SHOT_GET, TRIG_CONT_COMMIT, TRIG_SHOT_COMMIT} trig_type;
    typedef enum logic [1:0] {TERM_NONE, TERM_LFCR, TERM_CRLF, TERM_ONE}
        term_type;
    typedef enum {SQ_IDLE, SQ_LAT, SQ_SIG, SQ_REF, SQ_AZ, SQ_AC} seq_type;
endpackage

// file: rdg_ctrl_checker.sv
// checker: port-level properties of the reading buffer control
`timescale 1ns/10ps
`default_nettype none
module rdg_ctrl_checker (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pready,
    input wire logic       pslverr,
    input wire logic       byte_ack,
    input wire logic [7:0] tx_byte,
    input wire logic       tx_valid,
    input wire logic       tx_last,
    input wire logic       srq,
    input wire logic       rdg_ready
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    apb_answer_a:
        assert property (psel && penable && !pready |=> pready)
        else $error("apb answer late");
    pready_pulse_a:
        assert property (pready |=> !pready) else $error("pready too long");
    err_ready_a:
        assert property (pslverr |-> pready) else $error("lone pslverr");
    reset_quiet_a:
        assert property ($rose(rst_n) |-> !tx_valid && !srq)
        else $error("output active after reset");
    hold_byte_a:
        assert property (tx_valid && !byte_ack && !psel
            |=> tx_valid && $stable(tx_byte)) else $error("byte not held");
    srq_pulse_a:
        assert property (srq |=> !srq) else $error("srq not a pulse");
    last_valid_a:
        assert property (tx_last |-> tx_valid) else $error("stray last");
    ready_pulse_a:
        assert property (rdg_ready |=> !rdg_ready) else $error("ready long");
    cover property (srq);
    cover property (tx_last && byte_ack);
    cover property (pslverr);
endmodule
bind rdg_ctrl rdg_ctrl_checker i_chk (.*);
`default_nettype wire

// file: host_model.sv
// partner: bus host that takes the reading bytes
`timescale 1ns/10ps
`default_nettype none
module host_model (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        hold,
    input  wire logic [7:0]  tx_byte,
    input  wire logic        tx_valid,
    input  wire logic        tx_last,
    output logic             byte_ack,
    output int               len,
    output int               strings,
    output logic      [15:0] tail
);
    int cnt;
    always @(posedge clk) begin
        if (!rst_n) begin
            byte_ack <= 1'h0;
            cnt <= 0;
            strings <= 0;
        end else if (tx_valid && !byte_ack && !hold) begin
            byte_ack <= 1'h1;
            tail <= {tail[7:0], tx_byte};
            cnt <= cnt + 1;
            if (tx_last) begin
                len <= cnt + 1;
                cnt <= 0;
                strings <= strings + 1;
            end
        end else
            byte_ack <= 1'h0;
    end
endmodule
`default_nettype wire

// file: reading_buffer_and_correction_control_bench.sv
// bench: fills the reading buffer and checks the byte stream
`timescale 1ns/10ps
`default_nettype none
module reading_buffer_and_correction_control_bench;
    import rdg_pkg::*;
    logic        clk, rst_n, psel, penable, pwrite, hold, perr;
    logic        pready, pslverr, byte_ack, tx_valid, tx_last, srq, blank;
    logic [7:0]  paddr, tx_byte;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] lfsr_q, tail, r [20];
    logic [7:0]  dig [4] = '{8'h01, 8'h00, 8'h02, 8'h01};
    logic [7:0]  trm [4] = '{CH_LF, CH_CR, 8'h41, CH_DEL};
    logic [7:0]  fm [4] = '{8'h00, 8'h00, 8'h00, 8'h01};
    logic [7:0]  rsp [4] = '{8'h01, 8'h00, 8'h01, 8'h00};
    int          bad_count, checks_done, srq_seen, len, strings, s0, n;
    int          srq_base;
    rdg_ctrl i_dut (.clk(clk), .rst_n(rst_n), .ce(1'h1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .line_50hz(1'h0), .byte_ack(byte_ack), .tx_byte(tx_byte),
        .tx_valid(tx_valid), .tx_last(tx_last), .srq(srq),
        .panel_lockout(), .display_blank(blank), .adc_integrate(),
        .adc_autozero(), .adc_autocal(), .rdg_ready());
    host_model i_host (.clk(clk), .rst_n(rst_n), .hold(hold),
        .tx_byte(tx_byte), .tx_valid(tx_valid), .tx_last(tx_last),
        .byte_ack(byte_ack), .len(len), .strings(strings), .tail(tail));
    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) if (srq === 1'h1) srq_seen++;
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // bytes per string: binary is fixed; text body plus 0, 1 or 2 ends
    function automatic logic [31:0] blen(input logic [7:0] t, f);
        return f[0] ? 32'(BIN_LEN) : TXT_BODY + ((t == CH_DEL) ? 0 :
            (t == CH_CR || t == CH_LF) ? 2 : 1);
    endfunction
    // last two bytes: the pair of terminators, or the single one
    function automatic logic [31:0] ending(input logic [7:0] t);
        if (t == CH_LF) return {16'h0, CH_CR, CH_LF};
        if (t == CH_CR) return {16'h0, CH_LF, CH_CR};
        return {24'h0, t};
    endfunction
    task automatic check(input string what, input logic [31:0] e, g);
        checks_done++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel    <= 1'h1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'h1;
        @(posedge clk);
        while (pready !== 1'h1) @(posedge clk);
        rd = prdata;
        perr = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
        @(posedge clk);
    endtask
    task automatic cmd(input logic [7:0] op, a);
        apb(1'h1, OFF_CMD, {16'h0, op, a});
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (30000) @(posedge clk);
        bad_count++;
        end_of_test;
    end
    initial begin
        {psel, penable, pwrite, hold, paddr, pwdata} = '0;
        rst_n = 1'h0;
        lfsr_q = 16'hA010;
        repeat (8) @(posedge clk);
        rst_n <= 1'h1;
        @(posedge clk);
        apb(1'h1, 8'h1C, 32'h0);
        check("unmapped", 32'h1, {31'h0, perr});
        cmd(OP_DEPTH, 8'h06);
        cmd(OP_ZCHK, 8'h00);
        cmd(OP_COMMIT, 8'h00);
        apb(1'h0, OFF_EVT, 32'h0);
        check("digit error", 32'h1, {31'h0, |rd});
        // depth kept at 0, channel 0 zero check off, other defaults
        apb(1'h0, OFF_CFG, 32'h0);
        check("config", 32'h00403090, rd);
        for (int c = 0; c < 4; c++) begin
            n = (dig[c] == 8'h00) ? 1 : 10 * dig[c];
            cmd(OP_DEPTH, dig[c]);
            cmd(OP_TERM, trm[c]);
            cmd(OP_FMT, fm[c]);
            cmd(OP_RESP, rsp[c]);
            cmd(OP_COMMIT, 8'h00);
            check("blank", fm[c], {31'h0, blank});
            hold <= 1'h1;
            s0 = strings;
            srq_base = srq_seen;
            for (int k = 0; k < n; k++) begin
                check("early tx", 32'h0, {31'h0, tx_valid});
                lfsr_q = lfsr(lfsr_q);
                r[k] = lfsr_q;
                apb(1'h1, OFF_RDG_IN, {16'h0, lfsr_q});
            end
            repeat (3) @(posedge clk);
            apb(1'h0, OFF_RDG_OUT, 32'h0);
            check("oldest", {16'h0, r[0]}, rd);
            check("srq", rsp[c], srq_seen - srq_base);
            hold <= 1'h0;
            for (int t = 0; t < 9000 && strings < s0 + n; t++) @(posedge clk);
            check("strings", n, strings - s0);
            check("length", blen(trm[c], fm[c]), len);
            if (c < 2)
                check("ending", ending(trm[c]), tail);
            else if (c == 2)
                check("end", ending(trm[c]), tail & 16'h00FF);
            else
                check("last rdg", {16'h0, r[n - 1]}, tail);
            repeat (4) @(posedge clk);
            check("empty", 32'h0, {31'h0, tx_valid});
        end
        // device clear: range 4, rate 3, zero check on, CR LF, rest zero
        cmd(OP_CLEAR, 8'h00);
        apb(1'h0, OFF_CFG, 32'h0);
        check("cleared", 32'h004030D0, rd);
        check("unblank", 32'h0, {31'h0, blank});
        end_of_test;
    end
endmodule
`default_nettype wire
